// *** rtl/oicc_pkg.sv ***
// Package for the onboard I/O channel configuration block.
// Assumes a single 125 MHz fabric clock and an active-low asynchronous reset.
package oicc_pkg;
    localparam int AI_CHANNELS         = 16;
    localparam int AI_BALANCED_PAIR_INPUT_LIMIT       = 8;
    localparam int AO_CHANNELS         = 4;
    localparam int DIO_LINES           = 4;
    localparam int AI_RANGES           = 4;
    localparam int CH_IDX_W            = 4;
    localparam int AO_IDX_W            = 2;
    localparam int DIO_IDX_W           = 2;
    localparam int CAL_W               = 32;
    localparam int READY_DELAY_NS      = 1000;
    localparam int CLK_PERIOD_NS       = 8;
    localparam int READY_DELAY_CYCLES  = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_CNT_W         = 8;
    localparam logic [AI_CHANNELS-1:0] DEF_TERM_MODE = 16'h0000;
    localparam logic [DIO_LINES-1:0]   DEF_DIO_DIR   = 4'h0;
    localparam logic [DIO_LINES-1:0]   DEF_IN_SYNC   = 4'hF;
    localparam logic [DIO_LINES-1:0]   DEF_OUT_SYNC  = 4'hF;

    typedef enum logic
    {
        OICC_REFERENCED_SINGLE_ENDED,
        OICC_BALANCED_PAIR_INPUT
    } oicc_term_e;

    typedef enum logic [1:0]
    {
        OICC_RANGE_10V,
        OICC_RANGE_5V,
        OICC_RANGE_2V,
        OICC_RANGE_1V
    } oicc_range_e;

    localparam logic [2*AI_CHANNELS-1:0] DEF_RANGE = 32'h00000000;
endpackage

// *** rtl/oicc_dio_line.sv ***
// One digital line: input synchroniser and optional output register.
// Assumes the pin input comes from outside the clock domain.
`timescale 1ns/100ps
module oicc_dio_line
    import oicc_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    input  wire logic pin_i,
    input  wire logic in_sync_en_i,
    input  wire logic out_reg_en_i,
    input  wire logic out_data_i,
    output logic      in_data_o,
    output logic      out_pin_o
);
    logic [2:0] sync_q;
    logic [2:0] next_sync_q;
    logic       stable;
    logic       next_stable;
    logic       out_q;
    logic       next_out_q;

    always_comb
    begin
        next_sync_q = {sync_q[1:0], pin_i};
        next_stable = (sync_q[1] == sync_q[2]) ? sync_q[2] : stable;
        next_out_q  = out_data_i;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sync_q <= 3'h0;
            stable <= 1'b0;
            out_q  <= 1'b0;
        end
        else
        begin
            sync_q <= next_sync_q;
            stable <= next_stable;
            out_q  <= next_out_q;
        end
    end

    // Input path always crosses domains; unsynchronised choice still takes the third synchroniser stage, unfiltered
    assign in_data_o = in_sync_en_i ? stable : sync_q[2];
    assign out_pin_o = out_reg_en_i ? out_q : out_data_i;
endmodule

// *** rtl/oicc_top.sv ***
// Onboard I/O channel configuration: analog settings, calibration constants, digital lines.
// Assumes the user logic keeps the loop-entry conditions; one clock, no register bus.
`timescale 1ns/100ps
module oicc_top
    import oicc_pkg::*;
#(
    parameter logic [AO_CHANNELS*CAL_W-1:0] AO_LSB_WEIGHT = '0,
    parameter logic [AO_CHANNELS*CAL_W-1:0] AO_OFFSET     = '0,
    parameter logic [AI_RANGES*CAL_W-1:0]   AI_LSB_WEIGHT = '0,
    parameter logic [AI_RANGES*CAL_W-1:0]   AI_OFFSET     = '0
)
(
    input  wire logic                        ref_clk_i,
    input  wire logic                        resetn_i,
    input  wire logic                        term_wr_i,
    input  wire logic [CH_IDX_W-1:0]         term_ch_i,
    input  wire logic                        term_balanced_pair_input_i,
    input  wire logic                        range_wr_i,
    input  wire logic [CH_IDX_W-1:0]         range_ch_i,
    input  wire logic [1:0]                  range_sel_i,
    output logic      [AI_CHANNELS-1:0]      term_mode_o,
    output logic      [2*AI_CHANNELS-1:0]    range_o,
    output logic                             term_reject_o,
    input  wire logic [AO_IDX_W-1:0]         ao_sel_i,
    output logic      [CAL_W-1:0]            ao_lsb_weight_o,
    output logic      [CAL_W-1:0]            ao_offset_o,
    input  wire logic [1:0]                  ai_range_sel_i,
    output logic      [CAL_W-1:0]            ai_lsb_weight_o,
    output logic      [CAL_W-1:0]            ai_offset_o,
    input  wire logic                        one_clock_loop_i,
    input  wire logic [DIO_LINES-1:0]        in_sync_en_i,
    input  wire logic [DIO_LINES-1:0]        out_sync_en_i,
    input  wire logic                        dir_wr_i,
    input  wire logic                        dir_port_i,
    input  wire logic [DIO_IDX_W-1:0]        dir_line_i,
    input  wire logic [DIO_LINES-1:0]        dir_val_i,
    input  wire logic                        dout_wr_i,
    input  wire logic [DIO_LINES-1:0]        dout_i,
    output logic      [DIO_LINES-1:0]        din_o,
    output logic                             din_valid_o,
    output logic                             ready_o,
    input  wire logic [DIO_LINES-1:0]        dio_pin_i,
    output logic      [DIO_LINES-1:0]        dio_pin_o,
    output logic      [DIO_LINES-1:0]        dio_oe_o
);
    logic [AI_CHANNELS-1:0]   term_mode;
    logic [AI_CHANNELS-1:0]   next_term_mode;
    logic [2*AI_CHANNELS-1:0] range_q;
    logic [2*AI_CHANNELS-1:0] next_range_q;
    logic                     term_reject;
    logic                     next_term_reject;
    logic [DIO_LINES-1:0]     dir_q;
    logic [DIO_LINES-1:0]     next_dir_q;
    logic [DIO_LINES-1:0]     dout_q;
    logic [DIO_LINES-1:0]     next_dout_q;
    logic [READY_CNT_W-1:0]   ready_cnt;
    logic [READY_CNT_W-1:0]   next_ready_cnt;
    logic [DIO_LINES-1:0]     out_reg_en;
    logic [DIO_LINES-1:0]     line_din;

    localparam logic [READY_CNT_W-1:0] READY_LAST = READY_CNT_W'(READY_DELAY_CYCLES);

    // Analog input settings
    always_comb
    begin
        next_term_mode   = term_mode;
        next_range_q     = range_q;
        next_term_reject = 1'b0;
        if (term_wr_i)
        begin
            if (term_balanced_pair_input_i && (32'(term_ch_i) >= AI_BALANCED_PAIR_INPUT_LIMIT))
            begin
                next_term_reject = 1'b1;
            end
            else
            begin
                next_term_mode[term_ch_i] = term_balanced_pair_input_i;
            end
        end
        if (range_wr_i)
        begin
            next_range_q[2*range_ch_i +: 2] = range_sel_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            term_mode   <= DEF_TERM_MODE;
            range_q     <= DEF_RANGE;
            term_reject <= 1'b0;
        end
        else
        begin
            term_mode   <= next_term_mode;
            range_q     <= next_range_q;
            term_reject <= next_term_reject;
        end
    end

    assign term_mode_o   = term_mode;
    assign range_o       = range_q;
    assign term_reject_o = term_reject;

    // Calibration constants, read-only
    assign ao_lsb_weight_o = AO_LSB_WEIGHT[ao_sel_i*CAL_W +: CAL_W];
    assign ao_offset_o     = AO_OFFSET[ao_sel_i*CAL_W +: CAL_W];
    assign ai_lsb_weight_o = AI_LSB_WEIGHT[ai_range_sel_i*CAL_W +: CAL_W];
    assign ai_offset_o     = AI_OFFSET[ai_range_sel_i*CAL_W +: CAL_W];

    // Digital lines, direction, ready
    always_comb
    begin
        next_dir_q     = dir_q;
        next_dout_q    = dout_q;
        next_ready_cnt = ready_cnt;
        if (ready_cnt != READY_LAST)
        begin
            next_ready_cnt = ready_cnt + READY_CNT_W'(1);
        end
        if (dir_wr_i && !one_clock_loop_i)
        begin
            if (dir_port_i)
            begin
                next_dir_q = dir_val_i;
            end
            else
            begin
                next_dir_q[dir_line_i] = dir_val_i[0];
            end
        end
        if (dout_wr_i && ready_o)
        begin
            next_dout_q = dout_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dir_q     <= DEF_DIO_DIR;
            dout_q    <= '0;
            ready_cnt <= '0;
        end
        else
        begin
            dir_q     <= next_dir_q;
            dout_q    <= next_dout_q;
            ready_cnt <= next_ready_cnt;
        end
    end

    assign ready_o = (ready_cnt == READY_LAST);
    // Outside the loop a zero-stage choice still gets one register
    assign out_reg_en = one_clock_loop_i ? out_sync_en_i : {DIO_LINES{1'b1}};

    genvar gi;
    generate
        for (gi = 0; gi < DIO_LINES; gi++)
        begin : g_line
            oicc_dio_line u_line
            (
                .ref_clk_i    (ref_clk_i),
                .resetn_i     (resetn_i),
                .pin_i        (dio_pin_i[gi]),
                .in_sync_en_i (in_sync_en_i[gi]),
                .out_reg_en_i (out_reg_en[gi]),
                .out_data_i   (dout_q[gi]),
                .in_data_o    (line_din[gi]),
                .out_pin_o    (dio_pin_o[gi])
            );
        end
    endgenerate

    assign dio_oe_o    = dir_q;
    assign din_o       = ready_o ? line_din : '0;
    assign din_valid_o = ready_o;

    sequence s_dir_req_in_loop;
        dir_wr_i && one_clock_loop_i;
    endsequence

    a_dir_loop_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_dir_req_in_loop |=> dio_oe_o == $past(dio_oe_o))
        else $error("direction changed inside loop");
    a_balanced_pair_input_reject: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (term_wr_i && term_balanced_pair_input_i && 32'(term_ch_i) >= AI_BALANCED_PAIR_INPUT_LIMIT) |=>
        term_reject_o && term_mode_o[$past(term_ch_i)] == 1'b0)
        else $error("high channel went differential");
    a_term_set: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (term_wr_i && 32'(term_ch_i) < AI_BALANCED_PAIR_INPUT_LIMIT) |=>
        term_mode_o[$past(term_ch_i)] == $past(term_balanced_pair_input_i))
        else $error("terminal mode not updated");
    a_range_set: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        range_wr_i |=> range_o[2*$past(range_ch_i) +: 2] == $past(range_sel_i))
        else $error("range not updated");
    a_din_invalid: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !ready_o |-> !din_valid_o && din_o == 4'h0)
        else $error("input valid while not ready");
    a_dout_drop: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (dout_wr_i && !ready_o) |=> dout_q == $past(dout_q))
        else $error("output taken while not ready");
    a_dir_port_set: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (dir_wr_i && dir_port_i && !one_clock_loop_i) |=> dio_oe_o == $past(dir_val_i))
        else $error("port direction not set");
    a_dir_stable: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !dir_wr_i |=> $stable(dio_oe_o))
        else $error("direction changed without request");
    a_out_reg_outside: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (!one_clock_loop_i && ready_o) ##1 (!one_clock_loop_i) |->
        dio_pin_o == $past(dout_q))
        else $error("outside loop output not registered");
    a_ready_rise: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(ready_o) |=> ready_o [*8])
        else $error("ready dropped");
endmodule

// *** tb/oicc_pin_model.sv ***
// Pin-side model: an outside device driving the lines the block releases.
// Assumes each enable is high while the block drives that line.
`timescale 1ns/100ps
module oicc_pin_model
    import oicc_pkg::*;
(
    input  wire logic [DIO_LINES-1:0] oe_i,
    input  wire logic [DIO_LINES-1:0] drv_i,
    input  wire logic [DIO_LINES-1:0] ext_i,
    output logic      [DIO_LINES-1:0] pin_o
);
    // A driven line loops back; a released one shows the outside level
    always_comb
    begin
        for (int i = 0; i < DIO_LINES; i++)
        begin
            pin_o[i] = oe_i[i] ? drv_i[i] : ext_i[i];
        end
    end
endmodule

// *** tb/oicc_top_tb.sv ***
// Self-checking bench for the I/O channel configuration block.
// Assumes the package, the design and the pin model are compiled first.
`timescale 1ns/100ps
module oicc_top_tb
    import oicc_pkg::*;
;
    logic                     clk = 1'b0, rstn = 1'b0, t_wr = 1'b0, t_balanced_pair_input = 1'b0;
    logic                     r_wr = 1'b0, lp = 1'b0, d_wr = 1'b0, d_port = 1'b0, o_wr = 1'b0;
    logic [CH_IDX_W-1:0]      t_ch = '0, r_ch = '0;
    logic [1:0]               r_sel = '0, ai_sel = '0;
    logic [AO_IDX_W-1:0]      ao_sel = '0;
    logic [DIO_IDX_W-1:0]     d_line = '0;
    logic [DIO_LINES-1:0]     in_se = '0, out_se = '0, d_val = '0, dout = '0, ext = 4'hF;
    logic [DIO_LINES-1:0]     din, pin_i, pin_o, oe;
    logic [AI_CHANNELS-1:0]   term;
    logic [2*AI_CHANNELS-1:0] rng;
    logic [CAL_W-1:0]         ao_w, ao_o, ai_w, ai_o;
    logic                     rej, dvalid, rdy;
    int                       bad_count = 0, compares = 0, cycles = 0;

    always #4 clk = ~clk;

    oicc_top #(
        .AO_LSB_WEIGHT({32'hA3, 32'hA2, 32'hA1, 32'hA0}),
        .AO_OFFSET    ({32'hB3, 32'hB2, 32'hB1, 32'hB0}),
        .AI_LSB_WEIGHT({32'hC3, 32'hC2, 32'hC1, 32'hC0}),
        .AI_OFFSET    ({32'hD3, 32'hD2, 32'hD1, 32'hD0})
    ) u_oicc_top (
        .ref_clk_i(clk), .resetn_i(rstn), .term_wr_i(t_wr), .term_ch_i(t_ch),
        .term_balanced_pair_input_i(t_balanced_pair_input), .range_wr_i(r_wr), .range_ch_i(r_ch), .range_sel_i(r_sel),
        .term_mode_o(term), .range_o(rng), .term_reject_o(rej), .ao_sel_i(ao_sel),
        .ao_lsb_weight_o(ao_w), .ao_offset_o(ao_o), .ai_range_sel_i(ai_sel),
        .ai_lsb_weight_o(ai_w), .ai_offset_o(ai_o), .one_clock_loop_i(lp),
        .in_sync_en_i(in_se), .out_sync_en_i(out_se), .dir_wr_i(d_wr), .dir_port_i(d_port),
        .dir_line_i(d_line), .dir_val_i(d_val), .dout_wr_i(o_wr), .dout_i(dout),
        .din_o(din), .din_valid_o(dvalid), .ready_o(rdy), .dio_pin_i(pin_i),
        .dio_pin_o(pin_o), .dio_oe_o(oe)
    );

    oicc_pin_model u_oicc_pin_model (.oe_i(oe), .drv_i(pin_o), .ext_i(ext), .pin_o(pin_i));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
    endtask

    task automatic term_set(input int ch, input logic balanced_pair_input);
        tick;
        t_wr <= 1'b1;
        t_ch <= ch[CH_IDX_W-1:0];
        t_balanced_pair_input <= balanced_pair_input;
        tick;
        t_wr <= 1'b0;
        #1;
    endtask

    task automatic dir_set(input logic port, input int line, input logic [3:0] val);
        tick;
        d_wr <= 1'b1;
        d_port <= port;
        d_line <= line[DIO_IDX_W-1:0];
        d_val <= val;
        tick;
        d_wr <= 1'b0;
        #1;
    endtask

    task automatic out_put(input logic [3:0] d);
        tick;
        o_wr <= 1'b1;
        dout <= d;
        tick;
        o_wr <= 1'b0;
        #1;
    endtask

    task automatic t_reset;
        int n;
        n = 0;
        #1;
        chk("term reset", 0, term);
        chk("range reset", 0, rng);
        chk("oe reset", 0, oe);
        chk("din not ready", 0, din);
        out_put(4'hF);
        tick(2);
        #1;
        chk("din masked", 0, din);
        chk("din valid low", 0, dvalid);
        while (rdy !== 1'b1 && n < 200)
        begin
            tick;
            #1;
            n++;
        end
        // Four edges since release pass before polling starts
        chk("ready delay", READY_DELAY_CYCLES - 4, n);
        chk("din valid", 1, dvalid);
        chk("dropped write", 0, pin_o);
        tick(2);
        #1;
        chk("din ready", 4'hF, din);
    endtask

    task automatic t_term;
        term_set(7, 1'b1);
        chk("term ch7", 16'h0080, term);
        chk("no reject", 0, rej);
        term_set(8, 1'b1);
        chk("reject", 1, rej);
        chk("term ch8", 16'h0080, term);
        tick;
        #1;
        chk("reject pulse", 0, rej);
        term_set(7, 1'b0);
        chk("term back", 0, term);
    endtask

    task automatic t_range;
        logic [2*AI_CHANNELS-1:0] ex;
        ex = '0;
        for (int s = 0; s < 4; s++)
        begin
            tick;
            r_wr <= 1'b1;
            r_ch <= 4'(s * 5);
            r_sel <= s[1:0];
            tick;
            r_wr <= 1'b0;
            #1;
            ex[10*s+:2] = s[1:0];
            chk("range", ex, rng);
        end
    endtask

    task automatic t_cal;
        for (int i = 0; i < 4; i++)
        begin
            tick;
            ao_sel <= i[1:0];
            ai_sel <= i[1:0];
            tick;
            #1;
            chk("ao weight", 32'hA0 + i, ao_w);
            chk("ao offset", 32'hB0 + i, ao_o);
            chk("ai weight", 32'hC0 + i, ai_w);
            chk("ai offset", 32'hD0 + i, ai_o);
        end
    endtask

    task automatic t_dio;
        dir_set(1'b1, 0, 4'hF);
        chk("oe port", 4'hF, oe);
        dir_set(1'b0, 2, 4'h0);
        chk("oe line", 4'hB, oe);
        tick;
        lp <= 1'b1;
        dir_set(1'b1, 0, 4'h0);
        chk("oe in loop", 4'hB, oe);
        out_put(4'h5);
        chk("loop direct", 4'h5, pin_o);
        chk("oe after loop write", 4'hB, oe);
        tick;
        out_se <= 4'hF;
        out_put(4'hA);
        chk("loop reg early", 4'h5, pin_o);
        tick;
        #1;
        chk("loop reg", 4'hA, pin_o);
        tick;
        lp <= 1'b0;
        out_se <= 4'h0;
        out_put(4'h3);
        chk("outside early", 4'hA, pin_o);
        tick;
        #1;
        chk("outside reg", 4'h3, pin_o);
        dir_set(1'b1, 0, 4'h0);
        tick(4);
        ext <= 4'h6;
        tick(2);
        #1;
        chk("din direct early", 4'hF, din);
        tick;
        #1;
        chk("din direct", 4'h6, din);
        tick(2);
        in_se <= 4'hF;
        ext <= 4'h9;
        tick(3);
        #1;
        chk("din filter early", 4'h6, din);
        tick;
        #1;
        chk("din filtered", 4'h9, din);
    endtask

    task automatic results;
        $display("Comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Cut a hang short well beyond the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            results;
        end
    end

    initial
    begin
        tick(16);
        rstn <= 1'b1;
        t_reset;
        t_term;
        t_range;
        t_cal;
        t_dio;
        results;
    end
endmodule
